// ### design/enc_step_filter.sv
// Trigger input filter and encoder trigger generator with AXI4-Lite registers
//
// Notes on behaviour
// - Filtered trigger rises only after raw input high for full filter time.
// - Filtered trigger falls only after raw input low for full filter time.
// - Filter time selectable 100 to 500 us in 100 us steps, reset 100.
// - Filtered edge lags the raw edge by the selected filter time.
// - Every trigger line uses the filter time of line 0.
// - Encoder triggers only while the enable bit is set; reset clear.
// - Resolution register 1 to 65535 pulses per rotation, reset 1.
// - With index option set, a rotation is the phase Z pulse.
// - Otherwise a rotation is phase A count reaching the resolution.
// - Trigger source selects phase A counting (default) or phase Z.
// - Window start mode counts pulses any time the window is open.
// - Trigger start mode counts only after filtered trigger in window.
// - Phase A reset point legal set depends on start mode; default trigger.
// - Per-rotation reset allows several phase A trigger points per turn.
// - Trigger each time phase A count reaches interval 1..65535; interval 0 never fires, reset 0.
// - Direction option uses phase B with phase A; reset cleared.
// - Reverse phase A triggers suppressed unless reverse option is set; phase Z triggers are not.
// - In phase Z mode the Z count clears on each encoder trigger.
// - Phase Z trigger at count equal to interval 1..1023, reset 1.
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ns
module enc_step_filter #(
  parameter int NLINES = 1
) (
  input  wire logic                   CORE_CLK,      // System clock
  input  wire logic                   RST,           // Sync reset, high
  input  wire logic [7:0]             S_AXI_AWADDR,  // Write address
  input  wire logic                   S_AXI_AWVALID, // Write address valid
  output logic                        S_AXI_AWREADY, // Write address ready
  input  wire logic [31:0]            S_AXI_WDATA,   // Write data
  input  wire logic [3:0]             S_AXI_WSTRB,   // Byte strobes
  input  wire logic                   S_AXI_WVALID,  // Write data valid
  output logic                        S_AXI_WREADY,  // Write data ready
  output logic [1:0]                  S_AXI_BRESP,   // Write response
  output logic                        S_AXI_BVALID,  // Write response valid
  input  wire logic                   S_AXI_BREADY,  // Write response ready
  input  wire logic [7:0]             S_AXI_ARADDR,  // Read address
  input  wire logic                   S_AXI_ARVALID, // Read address valid
  output logic                        S_AXI_ARREADY, // Read address ready
  output logic [31:0]                 S_AXI_RDATA,   // Read data
  output logic [1:0]                  S_AXI_RRESP,   // Read response
  output logic                        S_AXI_RVALID,  // Read data valid
  input  wire logic                   S_AXI_RREADY,  // Read data ready
  input  wire logic [NLINES-1:0]      STEP_IN,       // Raw trigger lines
  input  wire logic                   ENC_A,         // Encoder phase A
  input  wire logic                   ENC_B,         // Encoder phase B
  input  wire logic                   ENC_Z,         // Encoder index
  input  wire logic                   ACCEPT_WIN,    // Trigger accept window
  output logic [NLINES-1:0]           STEP_FILT,     // Filtered lines
  output logic                        MEAS_START,    // Line 0 rise pulse
  output logic                        ENC_TRIG       // Encoder trigger pulse
);

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction : merge

  function automatic logic [8:0] lim_of(input logic [2:0] sel);
    return 9'((int'(sel) + 1) * enc_step_pkg::FILT_UNIT_US);
  endfunction : lim_of

  // Register state
  logic [31:0] ctrl_ff;
  logic [15:0] res_ff;
  logic [15:0] pha_ff;
  logic [9:0]  phz_ff;

  logic       enc_en, rot_z, src_z, a_step, dir_en, rev_en, z_step;
  logic [1:0] a_rst_sel;
  logic [2:0] filt_sel;
  assign enc_en    = ctrl_ff[enc_step_pkg::CTRL_EN];
  assign rot_z     = ctrl_ff[enc_step_pkg::CTRL_ROT_Z];
  assign src_z     = ctrl_ff[enc_step_pkg::CTRL_SRC_Z];
  assign a_step    = ctrl_ff[enc_step_pkg::CTRL_A_STEP];
  assign a_rst_sel = ctrl_ff[enc_step_pkg::CTRL_A_RST_LO +: 2];
  assign dir_en    = ctrl_ff[enc_step_pkg::CTRL_DIR_EN];
  assign rev_en    = ctrl_ff[enc_step_pkg::CTRL_REV_EN];
  assign z_step    = ctrl_ff[enc_step_pkg::CTRL_Z_STEP];
  assign filt_sel  = ctrl_ff[enc_step_pkg::CTRL_FILT_LO +: 3];

  // Pin synchronisers
  logic [NLINES-1:0] st_s1_ff, st_s2_ff;
  logic [2:0]        enc_s1_ff, enc_s2_ff, enc_s3_ff;
  logic              win_s1_ff, win_s2_ff;
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      st_s1_ff  <= '0;
      st_s2_ff  <= '0;
      enc_s1_ff <= 3'h0;
      enc_s2_ff <= 3'h0;
      enc_s3_ff <= 3'h0;
      win_s1_ff <= 1'b0;
      win_s2_ff <= 1'b0;
    end else begin
      st_s1_ff  <= STEP_IN;
      st_s2_ff  <= st_s1_ff;
      enc_s1_ff <= {ENC_Z, ENC_B, ENC_A};
      enc_s2_ff <= enc_s1_ff;
      enc_s3_ff <= enc_s2_ff;
      win_s1_ff <= ACCEPT_WIN;
      win_s2_ff <= win_s1_ff;
    end
  end

  // 1 us tick
  logic [4:0] div_ff;
  logic       tick;
  assign tick = (div_ff == 5'(enc_step_pkg::TICK_CYC - 1));
  always_ff @(posedge CORE_CLK) begin
    if (RST || tick) div_ff <= 5'h00;
    else div_ff <= div_ff + 5'h01;
  end

  // Shared limit, so all lines follow the line 0 setting
  logic [8:0] lim_us;
  assign lim_us = lim_of(filt_sel);

  logic [NLINES-1:0] filt_ff;
  logic [8:0]        fcnt_ff [NLINES];
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      filt_ff <= '0;
      for (int i = 0; i < NLINES; i++) fcnt_ff[i] <= 9'h000;
    end else begin
      for (int i = 0; i < NLINES; i++) begin
        if (st_s2_ff[i] == filt_ff[i]) begin
          fcnt_ff[i] <= 9'h000;
        end else if (tick) begin
          // Whole ticks only, so a level never passes early
          if (fcnt_ff[i] >= lim_us) begin
            filt_ff[i] <= st_s2_ff[i];
            fcnt_ff[i] <= 9'h000;
          end else begin
            fcnt_ff[i] <= fcnt_ff[i] + 9'h001;
          end
        end
      end
    end
  end
  assign STEP_FILT = filt_ff;

  logic filt0_d_ff, meas_ff, step_seen_ff;
  logic step_rise;
  assign step_rise = filt_ff[0] & ~filt0_d_ff;
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      filt0_d_ff   <= 1'b0;
      meas_ff      <= 1'b0;
      step_seen_ff <= 1'b0;
    end else begin
      filt0_d_ff <= filt_ff[0];
      meas_ff    <= step_rise;
      // Trigger seen inside the window arms trigger-start counting
      if (!win_s2_ff) step_seen_ff <= 1'b0;
      else if (step_rise) step_seen_ff <= 1'b1;
    end
  end
  assign MEAS_START = meas_ff;

  // Encoder edges; B high at A rise means reverse turning
  logic a_rise, z_rise, reverse, a_ok, a_gate, z_gate;
  assign a_rise  = enc_s2_ff[0] & ~enc_s3_ff[0];
  assign z_rise  = enc_s2_ff[2] & ~enc_s3_ff[2];
  assign reverse = dir_en & enc_s2_ff[1];
  assign a_ok    = a_rise & (~reverse | rev_en);
  assign a_gate  = enc_en & win_s2_ff & (~a_step | step_seen_ff);
  assign z_gate  = enc_en & win_s2_ff & (~z_step | step_seen_ff);

  // Illegal reset point for the start mode falls back to per trigger
  enc_step_pkg::areset_type a_mode;
  always_comb begin
    a_mode = enc_step_pkg::RST_PER_TRIG;
    if (a_rst_sel == enc_step_pkg::RST_PER_ROT && !a_step)
      a_mode = enc_step_pkg::RST_PER_ROT;
    if (a_rst_sel == enc_step_pkg::RST_PER_STEP && a_step)
      a_mode = enc_step_pkg::RST_PER_STEP;
  end

  logic [15:0] rot_cnt_ff;
  logic        rot_ev, rev_ff;
  assign rot_ev = rot_z ? z_rise
                        : (a_ok && rot_cnt_ff + 16'h0001 >= res_ff);
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      rot_cnt_ff <= 16'h0000;
      rev_ff     <= 1'b0;
    end else begin
      if (a_rise) rev_ff <= reverse;
      if (rot_ev) rot_cnt_ff <= 16'h0000;
      else if (a_ok) rot_cnt_ff <= rot_cnt_ff + 16'h0001;
    end
  end

  logic [15:0] a_cnt_ff, a_next_ff, a_tgt;
  logic        a_hit;
  assign a_tgt = (a_mode == enc_step_pkg::RST_PER_ROT) ? a_next_ff : pha_ff;
  // Interval 0 never fires
  assign a_hit = a_gate & a_ok & (pha_ff != 16'h0000)
                 & (a_cnt_ff + 16'h0001 == a_tgt);
  always_ff @(posedge CORE_CLK) begin
    if (RST || !enc_en) begin
      a_cnt_ff  <= 16'h0000;
      a_next_ff <= pha_ff;
    end else if ((a_mode == enc_step_pkg::RST_PER_ROT && rot_ev) ||
                 (a_mode == enc_step_pkg::RST_PER_STEP && step_rise)) begin
      a_cnt_ff  <= 16'h0000;
      a_next_ff <= pha_ff;
    end else begin
      if (a_mode != enc_step_pkg::RST_PER_ROT) a_next_ff <= pha_ff;
      if (a_hit && a_mode == enc_step_pkg::RST_PER_ROT) begin
        a_cnt_ff  <= a_cnt_ff + 16'h0001;
        a_next_ff <= a_next_ff + pha_ff;
      end else if (a_hit && a_mode == enc_step_pkg::RST_PER_TRIG) begin
        a_cnt_ff  <= 16'h0000;
      end else if (a_gate && a_ok) begin
        a_cnt_ff  <= a_cnt_ff + 16'h0001;
      end
    end
  end

  logic [9:0] z_cnt_ff;
  logic       z_hit;
  assign z_hit = z_gate & z_rise & (z_cnt_ff + 10'h001 == phz_ff);
  always_ff @(posedge CORE_CLK) begin
    if (RST || !enc_en) z_cnt_ff <= 10'h000;
    else if (z_hit) z_cnt_ff <= 10'h000;
    else if (z_gate && z_rise) z_cnt_ff <= z_cnt_ff + 10'h001;
  end

  logic trig_ff;
  always_ff @(posedge CORE_CLK) begin
    if (RST) trig_ff <= 1'b0;
    else trig_ff <= enc_en & (src_z ? z_hit : a_hit);
  end
  assign ENC_TRIG = trig_ff;

  // AXI4-Lite slave; address and data taken in either order
  logic        aw_ok_ff, w_ok_ff, bvalid_ff, rvalid_ff;
  logic [7:0]  awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0]  wstrb_ff;
  logic [1:0]  bresp_ff, rresp_ff;
  logic        do_wr;
  assign S_AXI_AWREADY = ~aw_ok_ff & ~bvalid_ff;
  assign S_AXI_WREADY  = ~w_ok_ff & ~bvalid_ff;
  assign S_AXI_ARREADY = ~rvalid_ff;
  assign do_wr = aw_ok_ff & w_ok_ff & ~bvalid_ff;
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      aw_ok_ff  <= 1'b0;
      w_ok_ff   <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= enc_step_pkg::RESP_OKAY;
      awaddr_ff <= 8'h00;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_ok_ff  <= 1'b1;
        awaddr_ff <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_ok_ff  <= 1'b1;
        wdata_ff <= S_AXI_WDATA;
        wstrb_ff <= S_AXI_WSTRB;
      end
      if (do_wr) begin
        aw_ok_ff  <= 1'b0;
        w_ok_ff   <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= (awaddr_ff <= enc_step_pkg::ADDR_PHZ &&
                      awaddr_ff[1:0] == 2'h0) ? enc_step_pkg::RESP_OKAY
                                              : enc_step_pkg::RESP_SLVERR;
      end else if (bvalid_ff && S_AXI_BREADY) begin
        bvalid_ff <= 1'b0;
      end
    end
  end
  assign S_AXI_BVALID = bvalid_ff;
  assign S_AXI_BRESP  = bresp_ff;

  logic [31:0] wr_ctrl;
  logic [15:0] wr_res;
  logic [9:0]  wr_phz;
  always_comb begin
    wr_ctrl = merge(ctrl_ff, wdata_ff, wstrb_ff) & enc_step_pkg::CTRL_MASK;
    // Out-of-range filter codes keep the old setting
    if (wr_ctrl[enc_step_pkg::CTRL_FILT_LO +: 3] > enc_step_pkg::FILT_SEL_MAX)
      wr_ctrl[enc_step_pkg::CTRL_FILT_LO +: 3] = filt_sel;
    wr_res = 16'(merge({16'h0000, res_ff}, wdata_ff, wstrb_ff));
    if (wr_res == 16'h0000) wr_res = res_ff;
    wr_phz = 10'(merge({22'h000000, phz_ff}, wdata_ff, wstrb_ff));
    if (wr_phz == 10'h000) wr_phz = phz_ff;
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ctrl_ff <= enc_step_pkg::CTRL_RST;
      res_ff  <= enc_step_pkg::RES_RST;
      pha_ff  <= enc_step_pkg::PHA_RST;
      phz_ff  <= enc_step_pkg::PHZ_RST;
    end else if (do_wr) begin
      unique case (awaddr_ff)
        enc_step_pkg::ADDR_CTRL: ctrl_ff <= wr_ctrl;
        enc_step_pkg::ADDR_RES:  res_ff  <= wr_res;
        enc_step_pkg::ADDR_PHA:
          pha_ff <= 16'(merge({16'h0000, pha_ff}, wdata_ff, wstrb_ff));
        enc_step_pkg::ADDR_PHZ:  phz_ff  <= wr_phz;
        default: ;
      endcase
    end
  end

  logic [31:0] rd_val;
  logic        rd_err;
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;
    unique case (S_AXI_ARADDR)
      enc_step_pkg::ADDR_CTRL: rd_val = ctrl_ff;
      enc_step_pkg::ADDR_RES:  rd_val[15:0] = res_ff;
      enc_step_pkg::ADDR_PHA:  rd_val[15:0] = pha_ff;
      enc_step_pkg::ADDR_PHZ:  rd_val[9:0]  = phz_ff;
      enc_step_pkg::ADDR_STAT: begin
        rd_val[NLINES-1:0] = filt_ff;
        rd_val[enc_step_pkg::STAT_SEEN] = step_seen_ff;
        rd_val[enc_step_pkg::STAT_REV]  = rev_ff;
        rd_val[enc_step_pkg::CNT_HI +: 16] = a_cnt_ff;
      end
      enc_step_pkg::ADDR_CNT: begin
        rd_val[9:0] = z_cnt_ff;
        rd_val[enc_step_pkg::CNT_HI +: 16] = rot_cnt_ff;
      end
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= enc_step_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_val;
      rresp_ff  <= rd_err ? enc_step_pkg::RESP_SLVERR
                          : enc_step_pkg::RESP_OKAY;
    end else if (rvalid_ff && S_AXI_RREADY) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign S_AXI_RVALID = rvalid_ff;
  assign S_AXI_RDATA  = rdata_ff;
  assign S_AXI_RRESP  = rresp_ff;

  // Checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  sequence s_rise_qualified;
    $past(tick) && $past(fcnt_ff[0]) == $past(lim_us);
  endsequence

  chk_filt_rise_time: assert property (
    $rose(filt_ff[0]) |-> s_rise_qualified and $past(st_s2_ff[0]))
    else $error("filtered rise before filter time");
  chk_filt_fall_time: assert property (
    $fell(filt_ff[0]) |-> s_rise_qualified and !$past(st_s2_ff[0]))
    else $error("filtered fall before filter time");
  chk_filt_restart: assert property (
    st_s2_ff[0] == filt_ff[0] |=> fcnt_ff[0] == 9'h000)
    else $error("filter counter did not restart");
  chk_filt_default: assert property (
    $past(RST) |-> lim_us == 9'(enc_step_pkg::FILT_UNIT_US))
    else $error("filter time not 100 us after reset");
  chk_enc_disabled: assert property (
    !enc_en |=> !ENC_TRIG)
    else $error("encoder trigger while disabled");
  chk_z_clear_trig: assert property (
    ENC_TRIG && $past(src_z) |-> z_cnt_ff == 10'h000)
    else $error("phase Z count not cleared on trigger");
  chk_z_interval: assert property (
    enc_en && src_z && z_gate && z_rise && z_cnt_ff == phz_ff - 10'h001
    |=> ENC_TRIG)
    else $error("phase Z trigger missed");
  chk_step_gate: assert property (
    a_step && !step_seen_ff && !rot_ev |=> a_cnt_ff <= $past(a_cnt_ff))
    else $error("counted before trigger input");
  chk_rev_block: assert property (
    !src_z && a_rise && reverse && !rev_en |=> !ENC_TRIG)
    else $error("reverse trigger not suppressed");

endmodule : enc_step_filter

// ### design/enc_step_pkg.sv
// Constants for the trigger filter and encoder trigger block
package enc_step_pkg;
  localparam int CLK_HZ       = 20_000_000;
  localparam int HZ_PER_MHZ   = 1_000_000;
  localparam int TICK_CYC     = (CLK_HZ + HZ_PER_MHZ - 1) / HZ_PER_MHZ;
  localparam int FILT_UNIT_US = 100;
  localparam logic [2:0] FILT_SEL_MAX = 3'h4;

  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RES  = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_PHA  = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_PHZ  = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_CNT  = 8'h14;

  localparam int CTRL_EN       = 0;
  localparam int CTRL_ROT_Z    = 1;
  localparam int CTRL_SRC_Z    = 2;
  localparam int CTRL_A_STEP   = 3;
  localparam int CTRL_A_RST_LO = 4;
  localparam int CTRL_DIR_EN   = 6;
  localparam int CTRL_REV_EN   = 7;
  localparam int CTRL_Z_STEP   = 8;
  localparam int CTRL_FILT_LO  = 16;
  localparam logic [31:0] CTRL_MASK = 32'h0007_01FF;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;

  localparam logic [15:0] RES_RST = 16'h0001;
  localparam logic [15:0] PHA_RST = 16'h0000;
  localparam logic [9:0]  PHZ_RST = 10'h001;

  localparam int STAT_SEEN = 8;
  localparam int STAT_REV  = 9;
  localparam int CNT_HI    = 16;

  typedef enum logic [1:0] {
    RST_PER_TRIG = 2'b00,
    RST_PER_ROT  = 2'b01,
    RST_PER_STEP = 2'b10
  } areset_type;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : enc_step_pkg

// ### verif/enc_source.sv
// Encoder and trigger source model for the step filter bench
`timescale 1ns/1ns
module enc_source (
  input  wire logic clk,   // Core clock
  output logic      enc_a, // Phase A
  output logic      enc_b, // Phase B
  output logic      enc_z, // Index pulse
  output logic      step,  // Raw trigger line
  output logic      win    // Trigger accept window
);
  initial begin
    win   = 1'b1;
    enc_a = 1'b0;
    enc_b = 1'b0;
    enc_z = 1'b0;
    step  = 1'b0;
  end

  // Reverse lets B lead, so B is already high when A rises
  task automatic turn(input int n, input logic rev);
    for (int i = 0; i < n; i++) begin
      repeat (8) @(posedge clk);
      {enc_a, enc_b} <= rev ? 2'h1 : 2'h2;
      repeat (8) @(posedge clk);
      {enc_a, enc_b} <= 2'h3;
      repeat (8) @(posedge clk);
      {enc_a, enc_b} <= rev ? 2'h2 : 2'h1;
      repeat (8) @(posedge clk);
      {enc_a, enc_b} <= 2'h0;
    end
    repeat (8) @(posedge clk);
  endtask : turn

  task automatic zpulse(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (8) @(posedge clk);
      enc_z <= 1'b1;
      repeat (8) @(posedge clk);
      enc_z <= 1'b0;
    end
  endtask : zpulse

  task automatic set_step(input logic v);
    step <= v;
  endtask : set_step

  task automatic set_win(input logic v);
    win <= v;
  endtask : set_win
endmodule : enc_source

// ### verif/testbench.sv
// Register-level bench for the trigger filter and encoder trigger block
`timescale 1ns/1ns
module testbench;
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready, win;
  logic        awready, wready, bvalid, arready, rvalid, a, b, z, stp;
  logic        filt, meas, trig;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          n_fail, total_checks, n_trig, n_meas, base;

  enc_step_filter i_dut (
    .CORE_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .STEP_IN(stp), .ENC_A(a), .ENC_B(b),
    .ENC_Z(z), .ACCEPT_WIN(win), .STEP_FILT(filt), .MEAS_START(meas),
    .ENC_TRIG(trig)
  );

  enc_source i_src (
    .clk(clk), .enc_a(a), .enc_b(b), .enc_z(z), .step(stp),
    .win(win)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    if (trig === 1'b1) n_trig <= n_trig + 1;
    if (meas === 1'b1) n_meas <= n_meas + 1;
  end

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic hang(input string nm);
    n_fail++;
    $display("CHECK FAILED %s expected answer seen timeout", nm);
    tally_and_finish();
  endtask : hang

  function automatic logic [31:0] rsp(input logic e);
    return {30'h0, e ? enc_step_pkg::RESP_SLVERR : enc_step_pkg::RESP_OKAY};
  endfunction : rsp

  // Ready is sampled mid-cycle, which equals its value at the next edge
  task automatic wr(input logic [7:0] ad, input logic [31:0] d,
                    input logic e, input logic [3:0] st = 4'hF);
    logic       ta, tw, tb;
    logic [1:0] r;
    awaddr <= ad;
    wstrb <= st;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    for (int i = 0; i < 40 && !tb; i++) begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (tb !== 1'b1) hang("write response");
    chk("write response", rsp(e), {30'h0, r});
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] ad, input logic [31:0] exp,
                    input logic e);
    logic        ta, tr;
    logic [31:0] d;
    logic [1:0]  r;
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    for (int i = 0; i < 40 && !tr; i++) begin
      @(negedge clk);
      ta = arvalid & arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (tr !== 1'b1) hang("read data");
    chk("read data", exp, d);
    chk("read response", rsp(e), {30'h0, r});
    @(posedge clk);
  endtask : rd

  task automatic trig_chk(input int exp);
    repeat (10) @(posedge clk);
    chk("trigger count", exp, n_trig - base);
    base = n_trig;
  endtask : trig_chk

  // Filtered level must hold until lo cycles, then flip within 80
  task automatic filt_wait(input logic v, input int lo);
    repeat (lo) @(posedge clk);
    @(negedge clk);
    chk("filter early", {31'h0, ~v}, {31'h0, filt});
    for (int i = 0; i < 80 && filt !== v; i++) @(negedge clk);
    chk("filter late", {31'h0, v}, {31'h0, filt});
    @(posedge clk);
  endtask : filt_wait

  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(enc_step_pkg::ADDR_CTRL, 32'h0, 0);
    rd(enc_step_pkg::ADDR_RES, 32'h1, 0);
    rd(enc_step_pkg::ADDR_PHA, 32'h0, 0);
    rd(enc_step_pkg::ADDR_PHZ, 32'h1, 0);
    rd(8'h20, 32'h0, 1);
    wr(8'h20, 32'h1, 1);
    wr(8'h02, 32'h1, 1);
    i_src.set_step(1'b1);
    filt_wait(1'b1, 2000);
    repeat (3) @(posedge clk);
    chk("start pulses", 32'h1, n_meas);
    i_src.set_step(1'b0);
    filt_wait(1'b0, 2000);
    // Pulse shorter than the filter must vanish
    i_src.set_step(1'b1);
    repeat (1000) @(posedge clk);
    i_src.set_step(1'b0);
    repeat (2100) @(posedge clk);
    chk("short pulse", 32'h0, {31'h0, filt});
    wr(enc_step_pkg::ADDR_CTRL, 32'h0001_0000, 0);
    wr(enc_step_pkg::ADDR_CTRL, 32'h0005_0000, 0);
    rd(enc_step_pkg::ADDR_CTRL, 32'h0001_0000, 0);
    i_src.set_step(1'b1);
    filt_wait(1'b1, 4000);
    i_src.set_step(1'b0);
    filt_wait(1'b0, 4000);
    wr(enc_step_pkg::ADDR_CTRL, 32'h0, 0);
    wr(enc_step_pkg::ADDR_PHA, 32'h1, 0);
    i_src.turn(4, 1'b0);
    trig_chk(0);
    wr(enc_step_pkg::ADDR_CTRL, 32'h1, 0);
    wr(enc_step_pkg::ADDR_PHA, 32'h3, 0);
    i_src.turn(7, 1'b0);
    trig_chk(2);
    i_src.set_win(1'b0);
    i_src.turn(3, 1'b0);
    trig_chk(0);
    i_src.set_win(1'b1);
    wr(enc_step_pkg::ADDR_CTRL, 32'h0, 0);
    wr(enc_step_pkg::ADDR_CTRL, 32'h41, 0);
    i_src.turn(6, 1'b1);
    trig_chk(0);
    i_src.turn(3, 1'b0);
    trig_chk(1);
    wr(enc_step_pkg::ADDR_CTRL, 32'hC1, 0);
    i_src.turn(6, 1'b1);
    trig_chk(2);
    wr(enc_step_pkg::ADDR_CTRL, 32'h0, 0);
    wr(enc_step_pkg::ADDR_RES, 32'h5, 0);
    wr(enc_step_pkg::ADDR_PHA, 32'h2, 0);
    wr(enc_step_pkg::ADDR_CTRL, 32'h11, 0);
    i_src.turn(10, 1'b0);
    trig_chk(4);
    wr(enc_step_pkg::ADDR_CTRL, 32'h0, 0);
    wr(enc_step_pkg::ADDR_RES, 32'hFFFF, 0);
    wr(enc_step_pkg::ADDR_RES, 32'h0, 0);
    rd(enc_step_pkg::ADDR_RES, 32'hFFFF, 0);
    wr(enc_step_pkg::ADDR_RES, 32'h0000_1234, 0, 4'h1);
    rd(enc_step_pkg::ADDR_RES, 32'h0000_FF34, 0);
    wr(enc_step_pkg::ADDR_CTRL, 32'h13, 0);
    i_src.turn(3, 1'b0);
    i_src.zpulse(1);
    i_src.turn(3, 1'b0);
    trig_chk(2);
    wr(enc_step_pkg::ADDR_CTRL, 32'h0, 0);
    wr(enc_step_pkg::ADDR_PHZ, 32'h2, 0);
    wr(enc_step_pkg::ADDR_CTRL, 32'h05, 0);
    i_src.turn(3, 1'b0);
    i_src.zpulse(5);
    trig_chk(2);
    wr(enc_step_pkg::ADDR_CTRL, 32'h0, 0);
    wr(enc_step_pkg::ADDR_PHA, 32'h1, 0);
    wr(enc_step_pkg::ADDR_CTRL, 32'h09, 0);
    i_src.turn(3, 1'b0);
    trig_chk(0);
    i_src.set_step(1'b1);
    repeat (2100) @(posedge clk);
    i_src.turn(2, 1'b0);
    trig_chk(2);
    rd(enc_step_pkg::ADDR_STAT, 32'h0000_0101, 0);
    rd(enc_step_pkg::ADDR_CNT, 32'h000B_0000, 0);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(enc_step_pkg::ADDR_CTRL, 32'h0, 0);
    rd(enc_step_pkg::ADDR_RES, 32'h1, 0);
    rd(enc_step_pkg::ADDR_STAT, 32'h0, 0);
    tally_and_finish();
  end
endmodule : testbench
